// file: logic/error_word_pkg.sv
package error_word_pkg;
    // register byte offsets
    localparam logic [7:0]  STATUS_OFS      = 8'h00;
    localparam logic [7:0]  MODE_OFS        = 8'h04;
    localparam logic [7:0]  EVENT_OFS       = 8'h08;
    localparam logic [7:0]  MASK_OFS        = 8'h0C;
    // error bit positions; bit n of the word sits at index n-1
    localparam int          BIT_SAT_RX      = 0;
    localparam int          BIT_PULSE       = 1;
    localparam int          BIT_ANALOGUE    = 2;
    localparam int          BIT_TELEGRAM    = 3;
    localparam int          BIT_QUARTZ2     = 4;
    localparam int          BIT_SAT_CMP     = 5;
    localparam int          BIT_PULSE_CMP   = 6;
    localparam int          BIT_ANA_CMP     = 7;
    localparam int          BIT_NOT_RADIO   = 8;
    localparam int          BIT_LOW_LIM     = 9;
    localparam int          BIT_HIGH_LIM    = 10;
    localparam int          BIT_MON_ERR     = 11;
    localparam int          BIT_IDLE_ERR    = 12;
    localparam int          WORD_W          = 16;
    // enabled edges after reset until the pin filter holds real levels
    localparam logic [2:0]  SYNC_FILL       = 3'h4;
    // mode field and mask reset values
    localparam logic [2:0]  MODE_RESET      = 3'h0;
    localparam logic [15:0] MASK_RESET      = 16'h0000;
    // axi responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // synchronisation mode selected by software
    typedef enum logic [2:0] {
        satellite_master_sync_mode         = 3'b000,
        longwave_pulse_sync_mode           = 3'b001,
        satellite_vs_telegram_compare_mode = 3'b010,
        pulse_vs_telegram_compare_mode     = 3'b011,
        analogue_vs_telegram_compare_mode  = 3'b100
    } sync_mode_t;
endpackage : error_word_pkg

// file: logic/pin_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output moves once stages two and three agree
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // shift chain and agreement filter
    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.o[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.o;
endmodule : pin_sync

// file: logic/error_word.sv
`timescale 1ns/100ps
// error status word with axi4-lite access, event flags and interrupt
module error_word (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // condition inputs from outside the clock domain
    input  wire logic        sat_reception_ok,
    input  wire logic        pulse_present_ok,
    input  wire logic        telegram_fault,
    input  wire logic        telegram_quartz2,
    input  wire logic        sat_time_differs,
    input  wire logic        pulse_time_differs,
    input  wire logic        radio_sync,
    input  wire logic        steer_at_low,
    input  wire logic        steer_at_high,
    input  wire logic        full_board_fault,
    input  wire logic        idle_board_silent,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // live word and interrupt
    output logic [15:0]      error_status,
    output logic             irq
);
    localparam int NIN = 11;

    typedef struct packed {
        logic [15:0]         word;
        logic [15:0]         event_flags;
        logic [15:0]         mask;
        error_word_pkg::sync_mode_t mode;
        logic                aw_held;
        logic [7:0]          aw_addr;
        logic                w_held;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [2:0]          fill;
    } regs_t;

    regs_t       r_q;
    regs_t       r_d;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] cond;
    logic [15:0] live;
    logic [15:0] w1c;
    logic        do_write;
    logic        do_read;
    logic        primed;

    assign raw_in = {idle_board_silent, full_board_fault, steer_at_high, steer_at_low, radio_sync,
                     pulse_time_differs, sat_time_differs, telegram_quartz2, telegram_fault,
                     pulse_present_ok, sat_reception_ok};

    // all condition pins pass the three-stage filter
    pin_sync #(.W(NIN)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .din     (raw_in),
        .dout    (cond)
    );

    // live condition decode
    always_comb begin
        live = '0;
        live[error_word_pkg::BIT_SAT_RX] = (r_q.mode == error_word_pkg::satellite_master_sync_mode) && !cond[0];
        live[error_word_pkg::BIT_PULSE] = (r_q.mode == error_word_pkg::longwave_pulse_sync_mode) && !cond[1];
        live[error_word_pkg::BIT_ANALOGUE] = 1'b0;
        live[error_word_pkg::BIT_ANA_CMP]  = 1'b0;
        live[error_word_pkg::BIT_TELEGRAM] = cond[2];
        live[error_word_pkg::BIT_QUARTZ2] = cond[3];
        live[error_word_pkg::BIT_SAT_CMP] =
            (r_q.mode == error_word_pkg::satellite_vs_telegram_compare_mode) && cond[4];
        live[error_word_pkg::BIT_PULSE_CMP] =
            (r_q.mode == error_word_pkg::pulse_vs_telegram_compare_mode) && cond[5];
        live[error_word_pkg::BIT_NOT_RADIO] = !cond[6];
        live[error_word_pkg::BIT_LOW_LIM] = cond[7];
        live[error_word_pkg::BIT_HIGH_LIM] = cond[8];
        live[error_word_pkg::BIT_MON_ERR] = cond[9];
        live[error_word_pkg::BIT_IDLE_ERR] = cond[9] || cond[10];
        live[15:13] = 3'h0;
    end

    assign do_write = r_q.aw_held && r_q.w_held && !r_q.bvalid;
    assign do_read  = s_axi_arvalid && !r_q.rvalid;
    // warm-up over: filter outputs no longer show their reset zeros
    assign primed   = (r_q.fill == error_word_pkg::SYNC_FILL);
    assign w1c      = (do_write && r_q.aw_addr == error_word_pkg::EVENT_OFS && r_q.w_strb[0] && r_q.w_strb[1])
                      ? r_q.w_data[15:0] : 16'h0000;

    // next-state: status tracking, events, bus slave
    always_comb begin
        r_d = r_q;
        // count enabled edges until the synchroniser holds real pin levels
        if (!primed) begin
            r_d.fill = r_q.fill + 3'h1;
        end
        // word follows live condition once the filter is filled
        r_d.word = primed ? live : 16'h0000;
        // rising error bits latch; set wins over clear; no false edge after reset
        r_d.event_flags = (r_q.event_flags & ~w1c) | (r_d.word & ~r_q.word);
        if (s_axi_awvalid && !r_q.aw_held) begin
            r_d.aw_held = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_q.w_held) begin
            r_d.w_held = 1'b1;
            r_d.w_data = s_axi_wdata;
            r_d.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            r_d.aw_held = 1'b0;
            r_d.w_held  = 1'b0;
            r_d.bvalid  = 1'b1;
            r_d.bresp   = error_word_pkg::RESP_OKAY;
            unique case (r_q.aw_addr)
                error_word_pkg::STATUS_OFS: begin
                end
                error_word_pkg::MODE_OFS: begin
                    if (r_q.w_strb[0]) begin
                        r_d.mode = error_word_pkg::sync_mode_t'(r_q.w_data[2:0]);
                    end
                end
                error_word_pkg::EVENT_OFS: begin
                end
                error_word_pkg::MASK_OFS: begin
                    if (r_q.w_strb[0]) begin
                        r_d.mask[7:0] = r_q.w_data[7:0];
                    end
                    if (r_q.w_strb[1]) begin
                        r_d.mask[15:8] = r_q.w_data[15:8];
                    end
                end
                default: begin
                    r_d.bresp = error_word_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (r_q.bvalid && s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end
        if (r_q.rvalid && s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end
        if (do_read) begin
            r_d.rvalid = 1'b1;
            r_d.rresp  = error_word_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                error_word_pkg::STATUS_OFS: r_d.rdata = {16'h0000, r_q.word};
                error_word_pkg::MODE_OFS:   r_d.rdata = {29'h0, r_q.mode};
                error_word_pkg::EVENT_OFS:  r_d.rdata = {16'h0000, r_q.event_flags};
                error_word_pkg::MASK_OFS:   r_d.rdata = {16'h0000, r_q.mask};
                default: begin
                    r_d.rdata = 32'h0000_0000;
                    r_d.rresp = error_word_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q      <= '0;
            r_q.mode <= error_word_pkg::satellite_master_sync_mode;
            r_q.mask <= error_word_pkg::MASK_RESET;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    // bus handshakes and outputs
    assign s_axi_awready = !r_q.aw_held;
    assign s_axi_wready  = !r_q.w_held;
    assign s_axi_bvalid  = r_q.bvalid;
    assign s_axi_bresp   = r_q.bresp;
    assign s_axi_arready = !r_q.rvalid;
    assign s_axi_rvalid  = r_q.rvalid;
    assign s_axi_rdata   = r_q.rdata;
    assign s_axi_rresp   = r_q.rresp;
    assign error_status  = r_q.word;
    assign irq           = |(r_q.event_flags & r_q.mask);

    a_unimpl_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !error_status[error_word_pkg::BIT_ANALOGUE] && !error_status[error_word_pkg::BIT_ANA_CMP])
        else $error("unimplemented error bit raised");
    a_high_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        error_status[15:13] == 3'h0) else $error("unassigned error bit raised");
    a_radio_loss: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed && !cond[6] |=> error_status[error_word_pkg::BIT_NOT_RADIO])
        else $error("bit 9 missed");
    a_sat_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        error_status[error_word_pkg::BIT_SAT_RX] |-> $past(r_q.mode) == error_word_pkg::satellite_master_sync_mode)
        else $error("bit 1 outside master mode");
    // bit 12 follows monitored fault only
    a_mon_implies: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed |=> error_status[error_word_pkg::BIT_MON_ERR] == $past(cond[9]))
        else $error("bit 12 not tracking monitored fault");
    a_idle_silent: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cond[10] |=> error_status[error_word_pkg::BIT_IDLE_ERR]) else $error("bit 13 missed");
    a_limit_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !cond[7] && !cond[8] |=> !error_status[9] && !error_status[10])
        else $error("limit bit stuck");
    a_low_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && cond[7] |=> error_status[error_word_pkg::BIT_LOW_LIM]) else $error("bit 10 missed");
    a_pulse_loss: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed && r_q.mode == error_word_pkg::longwave_pulse_sync_mode && !cond[1]
        |=> error_status[error_word_pkg::BIT_PULSE]) else $error("bit 2 missed");
    a_telegram_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed |=> error_status[error_word_pkg::BIT_TELEGRAM] == $past(cond[2]))
        else $error("bit 4 not tracking telegram");
    a_quartz_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed |=> error_status[error_word_pkg::BIT_QUARTZ2] == $past(cond[3]))
        else $error("bit 5 not tracking quartz report");
    a_sat_compare: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed && r_q.mode == error_word_pkg::satellite_vs_telegram_compare_mode && cond[4]
        |=> error_status[error_word_pkg::BIT_SAT_CMP]) else $error("bit 6 missed");
    a_pulse_compare: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed && r_q.mode == error_word_pkg::pulse_vs_telegram_compare_mode && cond[5]
        |=> error_status[error_word_pkg::BIT_PULSE_CMP]) else $error("bit 7 missed");
    a_high_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed && cond[8] |=> error_status[error_word_pkg::BIT_HIGH_LIM])
        else $error("bit 11 missed");
    a_idle_exact: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && primed |=> error_status[error_word_pkg::BIT_IDLE_ERR] == $past(cond[9] || cond[10]))
        else $error("bit 13 not tracking board faults");
    a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
endmodule : error_word

// file: test/cond_source.sv
`timescale 1ns/100ps
// far-side sources: receivers, telegram input, steering loop and boards
module cond_source (
    input  wire logic        aclk,
    input  wire logic [10:0] cv,
    output logic      [10:0] lv
);
    // source levels move just after a clock edge, like real pins
    always_ff @(posedge aclk) begin
        lv <= cv;
    end
endmodule : cond_source

// file: test/testbench.sv
`timescale 1ns/100ps
// self-checking bench for the error status word
module testbench;
    logic        aclk, aresetn, ce;
    logic [10:0] cv, lv, v;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [15:0] status, wd, ev, mask_m;
    logic [2:0]  mode_m;
    logic [50:0] rq[$];
    logic [1:0]  bq[$];
    logic [50:0] n;
    int          failures, comparisons;

    cond_source src (.aclk(aclk), .cv(cv), .lv(lv));
    error_word DUT (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .sat_reception_ok(lv[0]), .pulse_present_ok(lv[1]), .telegram_fault(lv[2]),
        .telegram_quartz2(lv[3]), .sat_time_differs(lv[4]), .pulse_time_differs(lv[5]),
        .radio_sync(lv[6]), .steer_at_low(lv[7]), .steer_at_high(lv[8]),
        .full_board_fault(lv[9]), .idle_board_silent(lv[10]),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .error_status(status), .irq(irq));

    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // expected live word from mode and source levels
    function automatic logic [15:0] word_of(input logic [2:0] m, input logic [10:0] c);
        logic [15:0] w;
        w = 16'h0000;
        w[0] = (m == 3'h0) && !c[0];
        w[1] = (m == 3'h1) && !c[1];
        w[5] = (m == 3'h2) && c[4];
        w[6] = (m == 3'h3) && c[5];
        w[3] = c[2];
        w[4] = c[3];
        w[8] = !c[6];
        w[11:9] = {c[9], c[8], c[7]};
        w[12] = c[9] | c[10];
        return w;
    endfunction : word_of

    // one comparison, mismatches reported at once
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // axi4-lite write, address and data offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask : axi_write

    // axi4-lite read; the note holds irq, resp, data and live word
    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({|(ev & mask_m), r, d, wd});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask : axi_read

    // let levels cross the synchroniser, then update the model
    task automatic settle();
        logic [15:0] w;
        repeat (8) @(posedge aclk);
        w = word_of(mode_m, cv);
        ev = ev | (w & ~wd);
        wd = w;
    endtask : settle

    // verdict and end of run
    task automatic tally_and_finish();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // compare every answer with the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
        end
        if (rvalid && rready) begin
            n = rq.pop_front();
            check("rdata", rdata, n[47:16]);
            check("rresp", {30'h0, rresp}, {30'h0, n[49:48]});
            check("status", {16'h0, status}, {16'h0, n[15:0]});
            check("irq", {31'h0, irq}, {31'h0, n[50]});
        end
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        void'($urandom(33074));
        {ce, aresetn, cv} = {1'b1, 1'b0, 11'h043};
        {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {failures, comparisons, ev, wd, mask_m, mode_m} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        // register reset values and an unmapped place
        axi_read(error_word_pkg::STATUS_OFS, 32'h0, 2'h0);
        axi_read(error_word_pkg::MODE_OFS, 32'h0, 2'h0);
        axi_read(error_word_pkg::EVENT_OFS, 32'h0, 2'h0);
        axi_read(error_word_pkg::MASK_OFS, 32'h0, 2'h0);
        axi_read(8'h10, 32'h0, 2'h2);
        axi_write(8'h10, 32'hFFFFFFFF, 2'h2);
        axi_write(error_word_pkg::STATUS_OFS, 32'hFFFFFFFF, 2'h0);
        axi_write(error_word_pkg::MASK_OFS, 32'hFFFFFFFF, 2'h0);
        mask_m = 16'hFFFF;
        axi_read(error_word_pkg::MASK_OFS, 32'h0000FFFF, 2'h0);
        // every mode: all faults, random levels, then all clear
        for (int m = 0; m < 5; m++) begin
            axi_write(error_word_pkg::MODE_OFS, 32'(m), 2'h0);
            mode_m = 3'(m);
            settle();
            axi_read(error_word_pkg::MODE_OFS, 32'(m), 2'h0);
            for (int k = 0; k < 5; k++) begin
                v = (k == 0) ? 11'h7BC : (k == 4) ? 11'h043 : 11'($urandom());
                cv <= v;
                settle();
                axi_read(error_word_pkg::STATUS_OFS, {16'h0, wd}, 2'h0);
            end
        end
        // sticky events, masking and write-one-to-clear
        axi_read(error_word_pkg::EVENT_OFS, {16'h0, ev}, 2'h0);
        axi_write(error_word_pkg::MASK_OFS, 32'h0, 2'h0);
        mask_m = 16'h0000;
        axi_read(error_word_pkg::EVENT_OFS, {16'h0, ev}, 2'h0);
        axi_write(error_word_pkg::MASK_OFS, 32'hFFFF, 2'h0);
        mask_m = 16'hFFFF;
        axi_write(error_word_pkg::EVENT_OFS, 32'hFFFF, 2'h0);
        ev = 16'h0000;
        axi_read(error_word_pkg::EVENT_OFS, 32'h0, 2'h0);
        repeat (2) @(posedge aclk);
        tally_and_finish();
    end
endmodule : testbench
